// File: keyscan_pkg.sv
/*
  Shared constants and types for the keypad matrix scanner with general
  purpose pins. Assumes a 250 MHz system clock and a simple register port.
*/
package keyscan_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int SYS_CLK_HZ     = 250_000_000;
  localparam int CLK_PER_US     = SYS_CLK_HZ / 1_000_000;
  localparam int SCAN_PERIOD_US = 4000;
  localparam int SCAN_PERIOD_CYC = SCAN_PERIOD_US * CLK_PER_US;
  localparam int SETTLE_NS      = 2000;
  localparam int SETTLE_CYC     = (SETTLE_NS * CLK_PER_US + 999) / 1000;

  // ****************************************************************
  // pin map
  // ****************************************************************
  localparam int NUM_ROWS = 8;
  localparam int NUM_COLS = 12;
  localparam int COL_BASE = 8;
  localparam int CFG2_PIN = 20;
  localparam int NUM_PINS = 21;
  localparam int SPECIAL_COL = 12;
  localparam int MIN_SIZE = 3;
  localparam int ROT_COLS = 9;
  localparam int FIFO_DEPTH = 15;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [3:0] ADDR_KEY_SIZE = 4'h0;
  localparam logic [3:0] ADDR_DEBOUNCE = 4'h1;
  localparam logic [3:0] ADDR_ACTIVE   = 4'h2;
  localparam logic [3:0] ADDR_CFG      = 4'h3;
  localparam logic [3:0] ADDR_DIR      = 4'h4;
  localparam logic [3:0] ADDR_STATE    = 4'h5;
  localparam logic [3:0] ADDR_PULL     = 4'h6;
  localparam logic [3:0] ADDR_FIFO     = 4'h7;
  localparam logic [3:0] ADDR_STATUS   = 4'h8;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int KS_ROW_LSB  = 4;
  localparam int CFG_ROT_EN  = 0;
  localparam int CFG_MUX_EN  = 1;
  localparam int CFG_PWM_EN  = 2;
  localparam int CFG_ERR_IRQ = 3;
  localparam logic [7:0]  KEY_SIZE_RST = 8'h33;
  localparam logic [7:0]  DEBOUNCE_RST = 8'h03;
  localparam logic [7:0]  ACTIVE_RST   = 8'h7D;
  localparam logic [3:0]  CFG_RST      = 4'h8;
  localparam logic [20:0] GPIO_RST     = 21'h000000;
  localparam logic [3:0]  SPECIAL_NIBBLE = 4'hF;
  localparam logic [7:0]  END_CODE     = 8'h00;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [23:0] wdata;
  } bus_req_t;

  typedef struct packed {
    logic [20:0] out;
    logic [20:0] oe;
    logic [20:0] pu;
    logic [20:0] pd;
  } pad_ctl_t;

  typedef enum logic [2:0] {
    ST_HALT    = 3'b000,
    ST_IDLE    = 3'b001,
    ST_SPECIAL = 3'b010,
    ST_COL     = 3'b011,
    ST_EVAL    = 3'b100,
    ST_ENC     = 3'b101
  } scan_state_t;

endpackage : keyscan_pkg

// File: keyscan_gpio.sv
/*
  Keypad matrix scanner: column drive, row sampling, debounce, event
  encoding into a 15 entry queue, interrupt, halt on inactivity, and
  general purpose pin control for pins the keypad does not use, except pins 17 to 19 in rotation mode and pin 20 with mux or PWM on.
  Assumes pin inputs and register strobes are synchronous to i_clk_sys.
*/
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
module keyscan_gpio
  import keyscan_pkg::*;
#(
  parameter int SCAN_CYC = SCAN_PERIOD_CYC
) (
  input  wire logic               i_clk_sys,
  input  wire logic               i_rst_n,
  input  wire bus_req_t           i_bus,
  output logic        [23:0]      o_rd_data,
  input  wire logic   [20:0]      i_pin,
  input  wire logic               i_cfg2_alt,
  output pad_ctl_t                o_pad,
  output logic                    o_irq,
  output logic                    o_halted
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [3:0] clamp(input logic [3:0] v,
                                       input logic [3:0] hi);
    if (v < 4'(MIN_SIZE)) return 4'(MIN_SIZE);
    else if (v > hi) return hi;
    else return v;
  endfunction : clamp

  function automatic logic two_or_more(input logic [11:0] v);
    return (v & (v - 12'h001)) != 12'h000;
  endfunction : two_or_more

  function automatic logic [3:0] ptr_inc(input logic [3:0] p);
    return (p == 4'(FIFO_DEPTH - 1)) ? 4'h0 : p + 4'h1;
  endfunction : ptr_inc

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]  key_size;
  logic [7:0]  debounce;
  logic [7:0]  active;
  logic [3:0]  cfg;
  logic [20:0] dir;
  logic [20:0] lvl;
  logic [20:0] pull;
  logic        err;
  logic        ovf;
  logic        irq_evt;

  logic wr_hit;
  logic rd_fifo;
  logic rd_stat;
  assign wr_hit  = i_bus.wr;
  assign rd_fifo = i_bus.rd && i_bus.addr == ADDR_FIFO;
  assign rd_stat = i_bus.rd && i_bus.addr == ADDR_STATUS;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      key_size <= KEY_SIZE_RST;
      debounce <= DEBOUNCE_RST;
      active   <= ACTIVE_RST;
      cfg      <= CFG_RST;
      dir      <= GPIO_RST;
      lvl      <= GPIO_RST;
      pull     <= GPIO_RST;
    end else if (wr_hit) begin
      case (i_bus.addr)
        ADDR_KEY_SIZE: key_size <= i_bus.wdata[7:0];
        ADDR_DEBOUNCE: begin
          if (i_bus.wdata[7:0] != 8'h00)
            debounce <= i_bus.wdata[7:0];
        end
        ADDR_ACTIVE:   active <= i_bus.wdata[7:0];
        ADDR_CFG:      cfg    <= i_bus.wdata[3:0];
        ADDR_DIR:      dir    <= i_bus.wdata[20:0];
        ADDR_STATE:    lvl    <= i_bus.wdata[20:0];
        ADDR_PULL:     pull   <= i_bus.wdata[20:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // keypad geometry
  // ****************************************************************
  logic [3:0] n_rows;
  logic [3:0] n_cols;
  assign n_rows = clamp(key_size[7:KS_ROW_LSB], 4'(NUM_ROWS));
  assign n_cols = clamp(key_size[3:0],
                        cfg[CFG_ROT_EN] ? 4'(ROT_COLS)
                                        : 4'(NUM_COLS));

  // ****************************************************************
  // scan timing
  // ****************************************************************
  scan_state_t st;
  logic [19:0] tick_cnt;
  logic        tick;
  logic [9:0]  settle;
  logic        settled;
  logic [3:0]  col;
  logic [2:0]  enc_r;
  logic [3:0]  enc_c;
  logic [7:0]  pend_cnt;
  logic [7:0]  act_cnt;

  assign tick    = tick_cnt == 20'(SCAN_CYC - 1);
  assign settled = settle == 10'(SETTLE_CYC - 1);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n)
      tick_cnt <= 20'h00000;
    else if (tick)
      tick_cnt <= 20'h00000;
    else
      tick_cnt <= tick_cnt + 20'h00001;
  end

  // ****************************************************************
  // sampled key images; column SPECIAL_COL holds special keys
  // ****************************************************************
  logic [7:0][12:0] snap;
  logic [7:0][12:0] stable;
  logic [7:0][12:0] pend;
  logic [7:0]       row_low;
  logic             diff;
  logic             ambig;
  logic [7:0]       row_multi;
  logic [11:0]      col_multi;
  logic             enc_diff;
  logic             enc_last;

  always_comb begin
    for (int r = 0; r < NUM_ROWS; r++)
      row_low[r] = !i_pin[r] && (3'(r) <= 3'(n_rows - 4'h1));
  end

  always_comb begin
    logic [7:0] cv;
    cv = 8'h00;
    for (int r = 0; r < NUM_ROWS; r++)
      row_multi[r] = two_or_more(snap[r][11:0]);
    for (int c = 0; c < NUM_COLS; c++) begin
      for (int r = 0; r < NUM_ROWS; r++)
        cv[r] = snap[r][c];
      col_multi[c] = two_or_more({4'h0, cv});
    end
    ambig = 1'b0;
    for (int r = 0; r < NUM_ROWS; r++)
      for (int c = 0; c < NUM_COLS; c++)
        if (snap[r][c] && row_multi[r] && col_multi[c])
          ambig = 1'b1;
  end

  assign diff     = snap != stable;
  assign enc_diff = snap[enc_r][enc_c] != stable[enc_r][enc_c];
  assign enc_last = enc_r == 3'(NUM_ROWS - 1) && enc_c == 4'(SPECIAL_COL);

  // ****************************************************************
  // scan state machine
  // ****************************************************************
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st       <= ST_IDLE;
      settle   <= 10'h000;
      col      <= 4'h0;
      enc_r    <= 3'h0;
      enc_c    <= 4'h0;
      pend_cnt <= 8'h00;
      act_cnt  <= 8'h00;
      snap     <= '0;
      stable   <= '0;
      pend     <= '0;
    end else begin
      case (st)
        ST_HALT: begin
          if (row_low != 8'h00 || wr_hit) begin
            st      <= ST_IDLE;
            act_cnt <= 8'h00;
          end
        end
        ST_IDLE: begin
          settle <= 10'h000;
          if (tick)
            st <= ST_SPECIAL;
        end
        ST_SPECIAL: begin
          settle <= settle + 10'h001;
          if (settled) begin
            for (int r = 0; r < NUM_ROWS; r++)
              snap[r][SPECIAL_COL] <= row_low[r];
            settle <= 10'h000;
            col    <= 4'h0;
            st     <= ST_COL;
          end
        end
        ST_COL: begin
          settle <= settle + 10'h001;
          if (settled) begin
            for (int r = 0; r < NUM_ROWS; r++)
              snap[r][col] <= row_low[r] && !snap[r][SPECIAL_COL];
            settle <= 10'h000;
            if (col == n_cols - 4'h1)
              st <= ST_EVAL;
            else
              col <= col + 4'h1;
          end
        end
        ST_EVAL: begin
          st <= ST_IDLE;
          if (!diff) begin
            pend_cnt <= 8'h00;
            pend     <= snap;
            act_cnt  <= act_cnt + 8'h01;
            if (active != 8'h00 && act_cnt + 8'h01 >= active)
              st <= ST_HALT;
          end else begin
            act_cnt <= 8'h00;
            if (ambig) begin
              pend_cnt <= 8'h00;
              pend     <= snap;
            end else if (snap != pend) begin
              pend     <= snap;
              pend_cnt <= 8'h00;
            end else if (pend_cnt + 8'h01 >= debounce) begin
              enc_r <= 3'h0;
              enc_c <= 4'h0;
              st    <= ST_ENC;
            end else begin
              pend_cnt <= pend_cnt + 8'h01;
            end
          end
        end
        ST_ENC: begin
          if (enc_diff)
            stable[enc_r][enc_c] <= snap[enc_r][enc_c];
          if (enc_c == 4'(SPECIAL_COL)) begin
            enc_c <= 4'h0;
            enc_r <= enc_r + 3'h1;
          end else begin
            enc_c <= enc_c + 4'h1;
          end
          if (enc_last) begin
            pend_cnt <= 8'h00;
            st       <= ST_IDLE;
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // event encoding
  // ****************************************************************
  logic       push;
  logic [7:0] code;
  assign push = st == ST_ENC && enc_diff;
  // press flag in bit 7 so rows 0 to 7 fill the rest of the upper nibble
  assign code = {snap[enc_r][enc_c], enc_r,
                 (enc_c == 4'(SPECIAL_COL)) ? SPECIAL_NIBBLE
                                            : enc_c + 4'h1};

  // ****************************************************************
  // event queue
  // ****************************************************************
  logic [7:0] mem [FIFO_DEPTH];
  logic [3:0] wr_ptr;
  logic [3:0] rd_ptr;
  logic [3:0] count;
  logic       returned;
  logic       pop;
  logic [3:0] cnt_after_pop;
  logic       full_now;
  logic       push_ok;
  logic [7:0] view;

  assign pop = returned && (push || rd_fifo) && count != 4'h0;
  assign cnt_after_pop = pop ? count - 4'h1 : count;
  assign full_now = cnt_after_pop == 4'(FIFO_DEPTH);
  assign push_ok  = push && !full_now;

  always_comb begin
    if (returned)
      view = (count >= 4'h2) ? mem[ptr_inc(rd_ptr)] : END_CODE;
    else
      view = (count != 4'h0) ? mem[rd_ptr] : END_CODE;
  end

  always_ff @(posedge i_clk_sys) begin
    if (push_ok)
      mem[wr_ptr] <= code;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr   <= 4'h0;
      rd_ptr   <= 4'h0;
      count    <= 4'h0;
      returned <= 1'b0;
    end else begin
      if (push_ok)
        wr_ptr <= ptr_inc(wr_ptr);
      if (pop)
        rd_ptr <= ptr_inc(rd_ptr);
      count <= cnt_after_pop + (push_ok ? 4'h1 : 4'h0);
      if (rd_fifo)
        returned <= view != END_CODE;
      else if (push)
        returned <= 1'b0;
    end
  end

  // ****************************************************************
  // status flags and interrupt
  // ****************************************************************
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      err     <= 1'b0;
      ovf     <= 1'b0;
      irq_evt <= 1'b0;
    end else begin
      if (st == ST_EVAL && diff && ambig)
        err <= 1'b1;
      else if (rd_stat)
        err <= 1'b0;
      if (push && full_now)
        ovf <= 1'b1;
      else if (rd_stat)
        ovf <= 1'b0;
      if (push_ok && count == 4'h0)
        irq_evt <= 1'b1;
      else if (rd_fifo)
        irq_evt <= 1'b0;
    end
  end

  assign o_irq    = irq_evt || (err && cfg[CFG_ERR_IRQ]);
  assign o_halted = st == ST_HALT;

  // ****************************************************************
  // read data
  // ****************************************************************
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= 24'h000000;
    end else if (i_bus.rd) begin
      case (i_bus.addr)
        ADDR_KEY_SIZE: o_rd_data <= {16'h0000, key_size};
        ADDR_DEBOUNCE: o_rd_data <= {16'h0000, debounce};
        ADDR_ACTIVE:   o_rd_data <= {16'h0000, active};
        ADDR_CFG:      o_rd_data <= {20'h00000, cfg};
        ADDR_DIR:      o_rd_data <= {3'h0, dir};
        ADDR_STATE:    o_rd_data <= {3'h0, lvl};
        ADDR_PULL:     o_rd_data <= {3'h0, pull};
        ADDR_FIFO:     o_rd_data <= {16'h0000, view};
        ADDR_STATUS:   o_rd_data <= {16'h0000, err, ovf,
                                     o_halted, 1'b0, count};
        default:       o_rd_data <= 24'h000000;
      endcase
    end else begin
      o_rd_data <= 24'h000000;
    end
  end

  // ****************************************************************
  // pad control
  // ****************************************************************
  pad_ctl_t next_pad;
  logic     scan_col_low;

  always_comb begin
    next_pad.oe  = dir;
    next_pad.out = lvl & dir;
    next_pad.pu  = ~dir & lvl & ~pull;
    next_pad.pd  = ~dir & lvl & pull;
    for (int r = 0; r < NUM_ROWS; r++) begin
      if (3'(r) <= 3'(n_rows - 4'h1)) begin
        next_pad.oe[r]  = 1'b0;
        next_pad.out[r] = 1'b0;
        next_pad.pu[r]  = 1'b1;
        next_pad.pd[r]  = 1'b0;
      end
    end
    for (int c = 0; c < NUM_COLS; c++) begin
      scan_col_low = st == ST_HALT || st == ST_IDLE
                  || st == ST_EVAL || st == ST_ENC
                  || (st == ST_COL && col == 4'(c));
      if (cfg[CFG_ROT_EN] && c >= ROT_COLS) begin
        next_pad.oe[COL_BASE + c]  = 1'b0;
        next_pad.out[COL_BASE + c] = 1'b0;
        next_pad.pu[COL_BASE + c]  = 1'b1;
        next_pad.pd[COL_BASE + c]  = 1'b0;
      end else if (4'(c) <= n_cols - 4'h1) begin
        next_pad.oe[COL_BASE + c]  = 1'b1;
        next_pad.out[COL_BASE + c] = !scan_col_low;
        next_pad.pu[COL_BASE + c]  = 1'b0;
        next_pad.pd[COL_BASE + c]  = 1'b0;
      end
    end
    if (cfg[CFG_MUX_EN] || cfg[CFG_PWM_EN]) begin
      next_pad.oe[CFG2_PIN]  = 1'b1;
      next_pad.out[CFG2_PIN] = i_cfg2_alt;
      next_pad.pu[CFG2_PIN]  = 1'b0;
      next_pad.pd[CFG2_PIN]  = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n)
      o_pad <= '0;
    else
      o_pad <= next_pad;
  end

endmodule : keyscan_gpio

// File: keyscan_gpio_chk.sv
/*
  Port checker for the keypad scanner, bound into every keyscan_gpio.
  Assumes one clock domain and that the keypad size stays 3x3 while
  the pin checks run.
*/
`timescale 1ns/1ns
module keyscan_gpio_chk
  import keyscan_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_rst_n,
  input wire bus_req_t    i_bus,
  input wire logic [23:0] o_rd_data,
  input wire logic [20:0] i_pin,
  input wire logic        i_cfg2_alt,
  input wire pad_ctl_t    o_pad,
  input wire logic        o_irq,
  input wire logic        o_halted
);
  // ****************************************************************
  // shadow registers
  // ****************************************************************
  localparam logic [20:0] GP = 21'h0FF8F8;
  logic [20:0] sdir, sst, spl, eoe, epu, epd;
  logic [7:0]  ssz;
  logic [3:0]  scfg;
  logic        pmux;
  logic [2:0]  plow;
  logic [15:0] hold;
  wire logic [2:0] low3 = o_pad.oe[10:8] & ~o_pad.out[10:8];
  wire logic       gp = (ssz == 8'h33) && !scfg[CFG_ROT_EN];
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sdir <= '0;
      sst <= '0;
      spl <= '0;
      ssz <= KEY_SIZE_RST;
      scfg <= CFG_RST;
    end else if (i_bus.wr) begin
      case (i_bus.addr)
        ADDR_DIR:      sdir <= i_bus.wdata[20:0];
        ADDR_STATE:    sst <= i_bus.wdata[20:0];
        ADDR_PULL:     spl <= i_bus.wdata[20:0];
        ADDR_KEY_SIZE: ssz <= i_bus.wdata[7:0];
        ADDR_CFG:      scfg <= i_bus.wdata[3:0];
        default:       ;
      endcase
    end
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      eoe <= '0;
      epu <= '0;
      epd <= '0;
      pmux <= 1'b0;
      plow <= '0;
      hold <= 16'(SETTLE_CYC);
    end else begin
      eoe <= sdir;
      epu <= ~sdir & sst & ~spl;
      epd <= ~sdir & sst & spl;
      pmux <= scfg[CFG_MUX_EN];
      plow <= low3;
      hold <= (low3 != plow) ? 16'h1 : hold + 16'(hold != 16'hFFFF);
    end
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence s_wake;
    o_halted && i_bus.wr;
  endsequence
  sequence s_rd_recent;
    $past(i_bus.rd) || $past(i_bus.rd, 2);
  endsequence
  chk_one_col_low: assert property ($countones(low3) != 2)
    else $error("two scan columns low at once");
  chk_rows_pulled: assert property ($past(i_rst_n) |->
    &o_pad.pu[2:0] && !(|o_pad.oe[2:0]))
    else $error("scan rows not pulled up");
  chk_settle_time: assert property (low3 != plow |->
    hold >= 16'(SETTLE_CYC))
    else $error("column phase shorter than settle time");
  chk_gpio_dir: assert property (gp && $past(gp) |->
    (o_pad.oe & GP) == (eoe & GP))
    else $error("pin drive differs from direction");
  chk_gpio_pulls: assert property (gp && $past(gp) |->
    (o_pad.pu & GP) == (epu & GP) && (o_pad.pd & GP) == (epd & GP))
    else $error("pin pulls differ from state and select");
  chk_cfg2_alt: assert property (scfg[CFG_MUX_EN] && pmux |->
    o_pad.oe[CFG2_PIN])
    else $error("config pin two not driven by mux");
  chk_irq_held: assert property ($fell(o_irq) |-> s_rd_recent)
    else $error("interrupt dropped without a read");
  chk_irq_rise: assert property ($rose(o_irq) |-> low3 != 3'h0)
    else $error("interrupt raised inside a scan");
  chk_halt_wake: assert property (s_wake |-> ##[1:3] !o_halted)
    else $error("register write did not wake");
endmodule : keyscan_gpio_chk

bind keyscan_gpio keyscan_gpio_chk CHK (.i_clk_sys, .i_rst_n, .i_bus,
  .o_rd_data, .i_pin, .i_cfg2_alt, .o_pad, .o_irq, .o_halted);

// File: keypad_model.sv
/*
  Passive key matrix with special keys that ground rows.
  Assumes the pad bundle of the scanner and its clock.
*/
`timescale 1ns/1ns
module keypad_model
  import keyscan_pkg::*;
(
  input wire logic             i_clk_sys,
  input wire pad_ctl_t         i_pad,
  input wire logic [7:0][11:0] i_keys,
  input wire logic [7:0]       i_special,
  output logic [20:0]          o_pin
);
  logic tog = 1'b0;
  always @(posedge i_clk_sys) tog <= ~tog;
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      if (i_pad.oe[p]) o_pin[p] = i_pad.out[p];
      else if (i_pad.pu[p]) o_pin[p] = 1'b1;
      else if (i_pad.pd[p]) o_pin[p] = 1'b0;
      else o_pin[p] = tog ^ p[0]; // floating pin wanders
    end
    for (int r = 0; r < NUM_ROWS; r++) begin
      if (i_special[r]) o_pin[r] = 1'b0;
      for (int c = 0; c < NUM_COLS; c++)
        if (i_keys[r][c] && !o_pin[COL_BASE+c]) o_pin[r] = 1'b0;
    end
  end
endmodule : keypad_model

// File: keyscan_gpio_test.sv
/*
  Self-checking bench for keyscan_gpio with a key matrix model.
  Assumes a shortened scan period so the run stays short.
*/
`timescale 1ns/1ns
module keyscan_gpio_test
  import keyscan_pkg::*;
;
  localparam int SC = 3000;
  localparam logic [23:0] RV [8] = '{24'h33, 24'h3, 24'h7D, 24'h8,
                                     24'h0, 24'h0, 24'h0, 24'h0};
  logic clk, rst_n, alt, irq, halted;
  bus_req_t bus;
  logic [23:0] rdd, d;
  logic [20:0] pin;
  pad_ctl_t pad;
  logic [7:0][11:0] keys;
  logic [7:0] spk;
  int n_errors, checked, n;

  keyscan_gpio #(.SCAN_CYC(SC)) DUT (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_bus(bus), .o_rd_data(rdd), .i_pin(pin), .i_cfg2_alt(alt),
    .o_pad(pad), .o_irq(irq), .o_halted(halted));
  keypad_model MATRIX (.i_clk_sys(clk), .i_pad(pad), .i_keys(keys),
    .i_special(spk), .o_pin(pin));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task test_done;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [23:0] v);
    @(posedge clk);
    bus <= '{1'b1, 1'b0, a, v};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  task rdc(input logic [3:0] a, input logic [23:0] e);
    @(posedge clk);
    bus <= '{1'b0, 1'b1, a, 24'h0};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(rdd, e);
  endtask : rdc
  task wirq;
    n = 0;
    while (irq !== 1'b1 && n < 4 * SC) begin
      @(posedge clk);
      n++;
    end
    chk(24'(irq), 24'h1);
  endtask : wirq
  task ev(input logic [7:0] a, input logic [7:0] b);
    wirq();
    chk(24'(n >= SC), 24'h1);
    // let the whole image be encoded before the queue is read
    repeat (120) @(posedge clk);
    rdc(ADDR_FIFO, 24'(a));
    chk(24'(irq), 24'h0);
    rdc(ADDR_FIFO, 24'(b));
    rdc(ADDR_FIFO, 24'h0);
  endtask : ev
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    alt = 1'b0;
    bus = '0;
    keys = '0;
    spk = '0;
    n_errors = 0;
    checked = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(24'(pad.pu[7:0]), 24'h7);
    chk(24'(pad.oe[10:8] & ~pad.out[10:8]), 24'h7);
    for (int i = 0; i < 8; i++) rdc(4'(i), RV[i]);
    rdc(4'hF, 24'h0);
    wr(ADDR_DEBOUNCE, 24'h0);
    rdc(ADDR_DEBOUNCE, 24'h3);
    wr(ADDR_DEBOUNCE, 24'h1);
    keys[1][2] <= 1'b1;
    ev(8'h93, 8'h00);
    keys <= '0;
    ev(8'h13, 8'h00);
    keys[0][0] <= 1'b1;
    keys[2][1] <= 1'b1;
    ev(8'h81, 8'hA2);
    wr(ADDR_ACTIVE, 24'h0);
    keys <= '0;
    ev(8'h01, 8'h22);
    wr(ADDR_ACTIVE, 24'h7D);
    spk[0] <= 1'b1;
    keys[0][1] <= 1'b1;
    ev(8'h8F, 8'h00);
    spk <= '0;
    keys <= '0;
    ev(8'h0F, 8'h00);
    keys[0][0] <= 1'b1;
    keys[0][1] <= 1'b1;
    keys[1][0] <= 1'b1;
    wirq();
    rdc(ADDR_STATUS, 24'h80);
    keys <= '0;
    repeat (3 * SC) @(posedge clk);
    rdc(ADDR_STATUS, 24'h00);
    wr(ADDR_KEY_SIZE, 24'h33);
    wr(ADDR_CFG, 24'h8);
    wr(ADDR_DIR, 24'h2000);
    wr(ADDR_PULL, 24'h4000);
    wr(ADDR_STATE, 24'hE000);
    repeat (2) @(posedge clk);
    #1 chk(24'(pad.oe[16:13]), 24'h1);
    chk(24'(pad.out[13]), 24'h1);
    chk(24'(pad.pu[16:13]), 24'h4);
    chk(24'(pad.pd[16:13]), 24'h2);
    rdc(ADDR_DIR, 24'h2000);
    wr(ADDR_CFG, 24'hA);
    for (int i = 1; i >= 0; i--) begin
      alt <= i[0];
      repeat (3) @(posedge clk);
      #1 chk(24'({pad.oe[20], pad.out[20]}), 24'({1'b1, i[0]}));
    end
    wr(ADDR_ACTIVE, 24'h2);
    n = 0;
    while (halted !== 1'b1 && n < 8 * SC) begin
      @(posedge clk);
      n++;
    end
    chk(24'(halted), 24'h1);
    wr(ADDR_ACTIVE, 24'h7D);
    repeat (3) @(posedge clk);
    #1 chk(24'(halted), 24'h0);
    test_done();
  end
  initial begin
    repeat (30 * SC) @(posedge clk);
    n_errors++;
    test_done();
  end
endmodule : keyscan_gpio_test
